// ---- rtl/ccp_pkg.sv ----
package ccp_pkg;

   localparam int unsigned ADDR_W         = 8;
   localparam logic [ADDR_W-1:0] OFF_CONTROL = 8'h00;
   localparam logic [ADDR_W-1:0] OFF_CMP_LOW = 8'h04;
   localparam logic [ADDR_W-1:0] OFF_CMP_HIGH = 8'h08;
   localparam logic [ADDR_W-1:0] OFF_STATUS  = 8'h0C;
   localparam logic [ADDR_W-1:0] OFF_TMR_SEL = 8'h10;
   localparam logic [ADDR_W-1:0] OFF_ALT_PIN = 8'h14;

   localparam int unsigned CTL_EOM_LSB   = 6;
   localparam int unsigned CTL_DUTY_LSB  = 4;
   localparam int unsigned STAT_FLAG_BIT = 0;
   localparam int unsigned STAT_PIN_BIT  = 1;
   localparam int unsigned STAT_PEND_BIT = 2;

   localparam logic [7:0]  RST_CONTROL  = 8'h00;
   localparam logic [7:0]  RST_CMP_BYTE = 8'h00;
   localparam logic [1:0]  RST_TMR_SEL  = 2'h0;
   localparam logic [9:0]  RST_DUTY     = 10'h000;

   localparam logic [1:0]  RESP_OKAY    = 2'h0;
   localparam logic [1:0]  RESP_SLVERR  = 2'h2;

   typedef enum logic [3:0] {
      MODE_OFF      = 4'b0000,
      MODE_TOGGLE   = 4'b0010,
      MODE_SET      = 4'b1000,
      MODE_CLEAR    = 4'b1001,
      MODE_SOFT_INT = 4'b1010,
      MODE_SPECIAL  = 4'b1011
   } ccp_mode_type;

   typedef struct packed {
      logic [ADDR_W-1:0] awaddr;
      logic              awvalid;
      logic [31:0]       wdata;
      logic [3:0]        wstrb;
      logic              wvalid;
      logic              bready;
      logic [ADDR_W-1:0] araddr;
      logic              arvalid;
      logic              rready;
   } ccp_axi_req_type;

   typedef struct packed {
      logic        awready;
      logic        wready;
      logic [1:0]  bresp;
      logic        bvalid;
      logic        arready;
      logic [31:0] rdata;
      logic [1:0]  rresp;
      logic        rvalid;
   } ccp_axi_rsp_type;

   typedef struct packed {
      logic [7:0] count;
      logic [1:0] fine;
      logic       period_match;
   } ccp_pwm_base_type;

endpackage : ccp_pkg

// ---- rtl/ccp_unit.sv ----
`timescale 1ns/10ps
module ccp_unit
   import ccp_pkg::*;
#(
   parameter bit ENHANCED   = 1'b0,
   parameter bit FIFTH_UNIT = 1'b0
)
(
   input  wire logic             i_sys_clk,
   input  wire logic             i_rst_n,
   input  wire ccp_axi_req_type  i_axi,
   output ccp_axi_rsp_type       o_axi,
   input  wire logic [15:0]      i_tmr_count,
   input  wire logic             i_tmr_clk_rise,
   input  wire logic             i_sleep,
   input  wire logic             i_adc_enabled,
   input  wire ccp_pwm_base_type i_pwm_base [3],
   output logic                  o_tmr_clear,
   output logic                  o_tmr_ovf_inhibit,
   output logic                  o_special_event,
   output logic                  o_adc_start,
   output logic                  o_match_flag,
   output logic                  o_pin_out,
   output logic                  o_pin_oe,
   output logic                  o_pin_alt_sel
);

   function automatic logic is_pwm(input logic [3:0] mode);
      is_pwm = (mode[3:2] == 2'b11);
   endfunction : is_pwm

   function automatic logic drives_pin(input logic [3:0] mode);
      drives_pin = is_pwm(mode) || (mode == MODE_TOGGLE) || (mode == MODE_SET) || (mode == MODE_CLEAR);
   endfunction : drives_pin

   logic [7:0]      control_q,  control_d;
   logic [7:0]      cmp_lo_q,   cmp_lo_d;
   logic [7:0]      cmp_hi_q,   cmp_hi_d;
   logic [1:0]      tmr_sel_q,  tmr_sel_d;
   logic            alt_q,      alt_d;
   logic            flag_q,     flag_d;
   logic            eq_q,       eq_d;
   logic            pend_q,     pend_d;
   logic            cmp_out_q,  cmp_out_d;
   logic [9:0]      duty_q,     duty_d;
   logic            pwm_out_q,  pwm_out_d;
   logic            clr_q,      clr_d;
   logic            sev_q,      sev_d;
   logic            adc_q,      adc_d;
   logic            pin_q,      pin_d;
   logic            oe_q,       oe_d;
   ccp_axi_rsp_type axi_q,      axi_d;

   logic [3:0]       mode;
   logic             equal;
   logic             match;
   logic             wr_go;
   logic             rd_go;
   logic             wr_hit;
   logic             rd_hit;
   logic [31:0]      rd_val;
   ccp_pwm_base_type base;
   logic [9:0]       time_base;

   always_comb
   begin
      mode      = control_q[3:0];
      base      = (tmr_sel_q == 2'd1) ? i_pwm_base[1] :
                  (tmr_sel_q == 2'd2) ? i_pwm_base[2] : i_pwm_base[0];
      time_base = {base.count, base.fine};
      equal     = (i_tmr_count == {cmp_hi_q, cmp_lo_q}) && !is_pwm(mode) && (mode != MODE_OFF);
      match     = equal && !eq_q && !i_sleep;

      wr_go  = axi_q.awready && i_axi.awvalid && i_axi.wvalid;
      rd_go  = axi_q.arready && i_axi.arvalid;
      wr_hit = (i_axi.awaddr == OFF_CONTROL) || (i_axi.awaddr == OFF_CMP_LOW) ||
               (i_axi.awaddr == OFF_CMP_HIGH) || (i_axi.awaddr == OFF_STATUS) ||
               (i_axi.awaddr == OFF_TMR_SEL) || (i_axi.awaddr == OFF_ALT_PIN);
      rd_hit = 1'b1;
      rd_val = 32'h0000_0000;
      case (i_axi.araddr)
         OFF_CONTROL:  rd_val[7:0] = control_q;
         OFF_CMP_LOW:  rd_val[7:0] = cmp_lo_q;
         OFF_CMP_HIGH: rd_val[7:0] = is_pwm(mode) ? duty_q[9:2] : cmp_hi_q;
         OFF_STATUS:   rd_val[2:0] = {pend_q, pin_q, flag_q};
         OFF_TMR_SEL:  rd_val[1:0] = tmr_sel_q;
         OFF_ALT_PIN:  rd_val[0]   = alt_q;
         default:      rd_hit      = 1'b0;
      endcase

      control_d = control_q;
      cmp_lo_d  = cmp_lo_q;
      cmp_hi_d  = cmp_hi_q;
      tmr_sel_d = tmr_sel_q;
      alt_d     = alt_q;
      cmp_out_d = cmp_out_q;
      flag_d    = flag_q;
      if (wr_go && i_axi.wstrb[0])
      begin
         case (i_axi.awaddr)
            OFF_CONTROL:
            begin
               control_d = i_axi.wdata[7:0];
               if (!ENHANCED)
               begin
                  control_d[7:CTL_EOM_LSB] = 2'b00;
               end
               if (i_axi.wdata[7:0] == 8'h00)
               begin
                  cmp_out_d = 1'b0;
               end
               else if (i_axi.wdata[3:0] == MODE_SET)
               begin
                  cmp_out_d = 1'b0;
               end
               else if (i_axi.wdata[3:0] == MODE_CLEAR)
               begin
                  cmp_out_d = 1'b1;
               end
            end
            OFF_CMP_LOW:  cmp_lo_d  = i_axi.wdata[7:0];
            OFF_CMP_HIGH:
            begin
               if (!is_pwm(mode))
               begin
                  cmp_hi_d = i_axi.wdata[7:0];
               end
            end
            OFF_STATUS:
            begin
               if (i_axi.wdata[STAT_FLAG_BIT])
               begin
                  flag_d = 1'b0;
               end
            end
            OFF_TMR_SEL:  tmr_sel_d = i_axi.wdata[1:0];
            OFF_ALT_PIN:  alt_d     = i_axi.wdata[0];
            default:      alt_d     = alt_q;
         endcase
      end

      // A match in the same cycle as a software clear keeps the flag set.
      if (match)
      begin
         flag_d = 1'b1;
         case (mode)
            MODE_TOGGLE: cmp_out_d = !cmp_out_q;
            MODE_SET:    cmp_out_d = 1'b1;
            MODE_CLEAR:  cmp_out_d = 1'b0;
            default:     cmp_out_d = cmp_out_d;
         endcase
      end

      eq_d  = equal;
      sev_d = match && (mode == MODE_SPECIAL);
      adc_d = sev_d && FIFTH_UNIT && i_adc_enabled;

      // The reset waits for the timer's own edge and is abandoned once equality is lost.
      // A timer edge in the match cycle itself is already the next edge, so a timer
      // that ticks on every clock is still reset instead of running past the period.
      pend_d = pend_q;
      clr_d  = 1'b0;
      if (!equal || (mode != MODE_SPECIAL))
      begin
         pend_d = 1'b0;
      end
      else if ((pend_q || match) && i_tmr_clk_rise)
      begin
         pend_d = 1'b0;
         clr_d  = 1'b1;
      end
      else if (match)
      begin
         pend_d = 1'b1;
      end

      // Duty is taken only at a period boundary, so a mid-period write cannot glitch the pin.
      duty_d    = duty_q;
      pwm_out_d = pwm_out_q;
      if (!is_pwm(mode))
      begin
         pwm_out_d = 1'b0;
      end
      else if (base.period_match)
      begin
         duty_d    = {cmp_lo_q, control_q[CTL_DUTY_LSB +: 2]};
         pwm_out_d = (duty_d != 10'h000);
      end
      else if (time_base == duty_q)
      begin
         pwm_out_d = 1'b0;
      end

      oe_d  = drives_pin(control_d[3:0]);
      pin_d = is_pwm(control_d[3:0]) ? pwm_out_d : cmp_out_d;

      // Ready waits for both write halves, so a lone address never leaves a half-taken write.
      axi_d         = axi_q;
      axi_d.awready = i_axi.awvalid && i_axi.wvalid && !axi_q.awready && !axi_q.bvalid;
      axi_d.wready  = axi_d.awready;
      axi_d.arready = i_axi.arvalid && !axi_q.arready && !axi_q.rvalid;
      if (axi_q.bvalid && i_axi.bready)
      begin
         axi_d.bvalid = 1'b0;
      end
      if (wr_go)
      begin
         axi_d.bvalid = 1'b1;
         axi_d.bresp  = wr_hit ? RESP_OKAY : RESP_SLVERR;
      end
      if (axi_q.rvalid && i_axi.rready)
      begin
         axi_d.rvalid = 1'b0;
      end
      if (rd_go)
      begin
         axi_d.rvalid = 1'b1;
         axi_d.rdata  = rd_val;
         axi_d.rresp  = rd_hit ? RESP_OKAY : RESP_SLVERR;
      end
   end

   always_ff @(posedge i_sys_clk)
   begin
      if (!i_rst_n)
      begin
         control_q <= RST_CONTROL;
         cmp_lo_q  <= RST_CMP_BYTE;
         cmp_hi_q  <= RST_CMP_BYTE;
         tmr_sel_q <= RST_TMR_SEL;
         alt_q     <= 1'b0;
         flag_q    <= 1'b0;
         eq_q      <= 1'b0;
         pend_q    <= 1'b0;
         cmp_out_q <= 1'b0;
         duty_q    <= RST_DUTY;
         pwm_out_q <= 1'b0;
         clr_q     <= 1'b0;
         sev_q     <= 1'b0;
         adc_q     <= 1'b0;
         pin_q     <= 1'b0;
         oe_q      <= 1'b0;
         axi_q     <= '0;
      end
      else
      begin
         control_q <= control_d;
         cmp_lo_q  <= cmp_lo_d;
         cmp_hi_q  <= cmp_hi_d;
         tmr_sel_q <= tmr_sel_d;
         alt_q     <= alt_d;
         flag_q    <= flag_d;
         eq_q      <= eq_d;
         pend_q    <= pend_d;
         cmp_out_q <= cmp_out_d;
         duty_q    <= duty_d;
         pwm_out_q <= pwm_out_d;
         clr_q     <= clr_d;
         sev_q     <= sev_d;
         adc_q     <= adc_d;
         pin_q     <= pin_d;
         oe_q      <= oe_d;
         axi_q     <= axi_d;
      end
   end

   // The clear pulse is a load of zero, never a wrap, so the overflow flag stays quiet.
   always_comb
   begin
      o_axi             = axi_q;
      o_tmr_clear       = clr_q;
      o_tmr_ovf_inhibit = clr_q;
      o_special_event   = sev_q;
      o_adc_start       = adc_q;
      o_match_flag      = flag_q;
      o_pin_out         = pin_q;
      o_pin_oe          = oe_q;
      o_pin_alt_sel     = alt_q;
   end

endmodule : ccp_unit

// ---- sim/ccp_unit_assertions.sv ----
`timescale 1ns/10ps
module ccp_unit_chk #(
   parameter bit FIFTH_UNIT = 1'h0
)
(
   input wire logic i_sys_clk,
   input wire logic i_rst_n,
   input wire logic i_tmr_clk_rise,
   input wire logic i_sleep,
   input wire logic o_tmr_clear,
   input wire logic o_tmr_ovf_inhibit,
   input wire logic o_special_event,
   input wire logic o_adc_start,
   input wire logic o_match_flag,
   input wire logic o_pin_oe
);
   default clocking cb @(posedge i_sys_clk);
   endclocking
   default disable iff (!i_rst_n);
   a_inhibit_pair:
      assert property (o_tmr_clear == o_tmr_ovf_inhibit) else $error("inhibit differs from clear");
   a_adc_start_cause:
      assert property (o_adc_start |-> o_special_event && FIFTH_UNIT) else $error("stray conversion start");
   a_event_once:
      assert property (o_special_event |=> !o_special_event) else $error("event repeated");
   a_event_sets_flag:
      assert property (o_special_event |-> o_match_flag) else $error("event without flag");
   a_event_no_pin:
      assert property (o_special_event |-> !o_pin_oe) else $error("pin driven in event mode");
   a_clear_on_tick:
      assert property (o_tmr_clear |-> $past(i_tmr_clk_rise)) else $error("clear without timer tick");
   a_clear_once:
      assert property (o_tmr_clear |=> !o_tmr_clear) else $error("clear longer than one cycle");
   a_flag_awake:
      assert property ($rose(o_match_flag) |-> !$past(i_sleep)) else $error("match while asleep");
endmodule : ccp_unit_chk

bind ccp_unit ccp_unit_chk #(.FIFTH_UNIT(FIFTH_UNIT)) u_chk (.i_sys_clk, .i_rst_n, .i_tmr_clk_rise, .i_sleep,
   .o_tmr_clear, .o_tmr_ovf_inhibit, .o_special_event, .o_adc_start, .o_match_flag, .o_pin_oe);

// ---- sim/ccp_tmr_model.sv ----
`timescale 1ns/10ps
module ccp_tmr_model (
   input  wire logic       i_sys_clk,
   input  wire logic       i_rst_n,
   input  wire logic [7:0] i_div,
   input  wire logic       i_zero,
   input  wire logic       i_clear,
   input  wire logic       i_inhibit,
   output logic [15:0]     o_count,
   output logic            o_tick,
   output logic            o_ovf_flag
);
   logic [7:0] pre_q;
   // Ticks are derived from the system clock, so the count is always synchronous.
   always_ff @(posedge i_sys_clk)
   begin
      if (!i_rst_n)
      begin
         pre_q      <= 8'h00;
         o_count    <= 16'h0000;
         o_tick     <= 1'h0;
         o_ovf_flag <= 1'h0;
      end
      else
      begin
         pre_q  <= (pre_q >= i_div - 8'h01) ? 8'h00 : pre_q + 8'h01;
         o_tick <= (pre_q == i_div - 8'h01);
         if (i_clear || i_zero)
         begin
            o_count <= 16'h0000;
            // A clear that comes without the inhibit is taken as a wrap.
            if (i_clear && !i_inhibit)
               o_ovf_flag <= 1'h1;
         end
         else if (o_tick)
            {o_ovf_flag, o_count} <= {o_ovf_flag | (&o_count), o_count + 16'h0001};
      end
   end
endmodule : ccp_tmr_model

// ---- sim/ccp_compare_and_pwm_entry_tb.sv ----
`timescale 1ns/10ps
module ccp_compare_and_pwm_entry_tb;
   import ccp_pkg::*;
   logic             i_sys_clk = 1'h0;
   logic             i_rst_n   = 1'h0;
   logic             adc_en    = 1'h0;
   logic             zero      = 1'h0;
   logic             sleep     = 1'h0;
   logic             dir_in    = 1'h1;
   logic [7:0]       div       = 8'h02;
   ccp_axi_req_type  ax        = '{bready: 1'h1, rready: 1'h1, wstrb: 4'hF, default: '0};
   ccp_axi_rsp_type  rs;
   ccp_pwm_base_type pb [3]    = '{default: '0};
   logic [15:0]      cnt;
   logic             tick, ovf, clr, sev, adc, flag, pin, oe, alt, inh;
   logic [31:0]      rd_d;
   logic [1:0]       rd_r;
   int               err_count = 0;
   int               comparisons = 0;
   int               mq[$] = '{2, 8, 9, 10, 11};
   int               eq[$] = '{3, 3, 2, 0, 0};

   ccp_unit #(.ENHANCED(1'h0), .FIFTH_UNIT(1'h1)) dut (.i_sys_clk(i_sys_clk), .i_rst_n(i_rst_n), .i_axi(ax),
      .o_axi(rs), .i_tmr_count(cnt), .i_tmr_clk_rise(tick), .i_sleep(sleep), .i_adc_enabled(adc_en),
      .i_pwm_base(pb), .o_tmr_clear(clr), .o_tmr_ovf_inhibit(inh), .o_special_event(sev), .o_adc_start(adc),
      .o_match_flag(flag), .o_pin_out(pin), .o_pin_oe(oe), .o_pin_alt_sel(alt));
   ccp_tmr_model tm (.i_sys_clk(i_sys_clk), .i_rst_n(i_rst_n), .i_div(div), .i_zero(zero), .i_clear(clr),
      .i_inhibit(inh), .o_count(cnt), .o_tick(tick), .o_ovf_flag(ovf));

   always #2.5 i_sys_clk = ~i_sys_clk;

   task automatic tally_and_finish;
      $display("comparisons %0d errors %0d", comparisons, err_count);
      if (err_count == 0 && comparisons > 0)
         $display("STATUS OK");
      else
         $display("STATUS NOT OK");
      $finish;
   endtask : tally_and_finish

   task automatic chk(input string nm, input logic [31:0] s, input logic [31:0] e);
      comparisons++;
      if (s !== e)
      begin
         err_count++;
         $display("ERROR %s expected %h seen %h", nm, e, s);
      end
   endtask : chk

   task automatic bound(input int n);
      if (n >= 20000)
      begin
         err_count++;
         tally_and_finish();
      end
   endtask : bound

   task automatic wr(input logic [7:0] a, input logic [7:0] d);
      int n;
      n = 0;
      ax.awaddr  <= a;
      ax.wdata   <= {24'h000000, d};
      ax.awvalid <= 1'h1;
      ax.wvalid  <= 1'h1;
      do
      begin
         @(posedge i_sys_clk);
         n++;
         if (rs.awready) ax.awvalid <= 1'h0;
         if (rs.wready) ax.wvalid <= 1'h0;
      end while (!rs.bvalid && n < 20000);
      bound(n);
   endtask : wr

   task automatic rd(input logic [7:0] a);
      int n;
      n = 0;
      ax.araddr  <= a;
      ax.arvalid <= 1'h1;
      do
      begin
         @(posedge i_sys_clk);
         n++;
         if (rs.arready) ax.arvalid <= 1'h0;
      end while (!rs.rvalid && n < 20000);
      rd_d = rs.rdata;
      rd_r = rs.rresp;
      bound(n);
   endtask : rd

   // A slow timer in the late case leaves room to move the compare value before the tick.
   task automatic run(input int k, input bit late);
      logic [15:0] v;
      int          n;
      int          m;
      v = 16'h0100 + 16'($urandom % 32);
      div    <= late ? 8'h28 : 8'h02;
      adc_en <= !late;
      wr(OFF_CONTROL, 8'h00);
      rd(OFF_STATUS);
      chk("latch", rd_d[STAT_PIN_BIT], 32'h0);
      zero <= 1'h1;
      @(posedge i_sys_clk);
      zero <= 1'h0;
      wr(OFF_CMP_LOW, v[7:0]);
      wr(OFF_CMP_HIGH, v[15:8]);
      wr(OFF_CONTROL, 8'(mq[k]));
      n = 0;
      do
      begin
         @(posedge i_sys_clk);
         n++;
      end while (!flag && n < 20000);
      bound(n);
      chk("count", cnt, v);
      chk("event", sev, k == 4);
      chk("adc", adc, k == 4 && !late);
      chk("pin", {oe, pin & oe & !dir_in}, eq[k]);
      if (late) wr(OFF_CMP_LOW, v[7:0] + 8'h05);
      n = 0;
      m = 0;
      repeat (90)
      begin
         @(posedge i_sys_clk);
         n += clr;
         m += inh;
      end
      chk("clears", n, k == 4 && !late);
      chk("inhibits", m, k == 4 && !late);
      chk("ovf", ovf, 32'h0);
      rd(OFF_STATUS);
      chk("flag", rd_d[STAT_FLAG_BIT], 32'h1);
      wr(OFF_STATUS, 8'h01);
      rd(OFF_STATUS);
      chk("flag clear", rd_d[STAT_FLAG_BIT], 32'h0);
   endtask : run

   initial
   begin
      void'($urandom(48386));
      repeat (12) @(posedge i_sys_clk);
      i_rst_n <= 1'h1;
      rd(OFF_CMP_HIGH);
      chk("reset", rd_d, 32'h0);
      rd(8'h40);
      chk("unmapped", rd_r, RESP_SLVERR);
      wr(OFF_CONTROL, 8'hF0);
      rd(OFF_CONTROL);
      chk("control", rd_d, 32'h30);
      wr(OFF_ALT_PIN, 8'h01);
      chk("alt", alt, 32'h1);
      dir_in <= 1'h0;
      for (int k = 0; k < 5; k++)
         run(k, 1'h0);
      run(4, 1'h1);
      // Asleep, the first equal cycle is lost and equality that persists cannot replace it.
      div   <= 8'h02;
      sleep <= 1'h1;
      wr(OFF_CONTROL, 8'h00);
      zero <= 1'h1;
      @(posedge i_sys_clk);
      zero <= 1'h0;
      wr(OFF_CMP_HIGH, 8'h00);
      wr(OFF_CMP_LOW, 8'h10);
      wr(OFF_CONTROL, 8'h0A);
      repeat (60) @(posedge i_sys_clk);
      chk("asleep", flag, 32'h0);
      sleep <= 1'h0;
      wr(OFF_TMR_SEL, 8'h01);
      wr(OFF_CMP_LOW, 8'h02);
      wr(OFF_CONTROL, 8'h0C);
      pb[0].period_match <= 1'h1;
      @(posedge i_sys_clk);
      pb[0].period_match <= 1'h0;
      @(posedge i_sys_clk);
      chk("pwm other", pin, 32'h0);
      pb[1].period_match <= 1'h1;
      @(posedge i_sys_clk);
      pb[1].period_match <= 1'h0;
      @(posedge i_sys_clk);
      chk("pwm set", {oe, pin}, 32'h3);
      pb[1].count <= 8'h02;
      repeat (2) @(posedge i_sys_clk);
      chk("pwm end", pin, 32'h0);
      wr(OFF_CONTROL, 8'h00);
      @(posedge i_sys_clk);
      chk("release", oe, 32'h0);
      tally_and_finish();
   end
endmodule : ccp_compare_and_pwm_entry_tb
